// ==== shared/mis_pkg.sv ====
// constants, types and decode helpers for message id screening
package mis_pkg;
    localparam int REF_COUNT = 5;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int START_W = 7;
    localparam int BIT_IDX_W = 5;
    localparam logic [5:0] REF15_IDX = 6'h0F;
    localparam logic [5:0] REF16_IDX = 6'h10;
    localparam logic [5:0] REF17_IDX = 6'h11;
    localparam logic [5:0] REF18_IDX = 6'h12;
    localparam logic [5:0] REF19_IDX = 6'h13;
    localparam logic [5:0] START_IDX = 6'h14;
    localparam logic [5:0] CTRL_IDX = 6'h15;
    localparam logic [5:0] STATUS_IDX = 6'h20;
    localparam logic [7:0] REF_RST = 8'h00;
    localparam logic [6:0] START_RST = 7'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam int CTRL_NTS_LSB = 0;
    localparam int CTRL_ORG_BIT = 2;
    localparam int CTRL_EN_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_MATCH_BIT = 2;
    // local positions (ref byte 15 = local 0) of whole identifier groups
    localparam int TWO_BASE0 = 1;
    localparam int TWO_BASE1 = 3;
    localparam int FOUR_BASE = 1;

    typedef enum logic [1:0] {
        MIS_IDLE = 2'b00,
        MIS_SKIP = 2'b01,
        MIS_CMP = 2'b11,
        MIS_REPORT = 2'b10
    } mis_state_t;

    // number of bytes to scan, 1 to 4
    function automatic logic [2:0] mis_scan_bytes(input logic org,
                                                  input logic [1:0] nts);
        if (org) begin
            mis_scan_bytes = {1'b0, nts} + 3'h1;
        end else begin
            mis_scan_bytes = (nts == 2'h0) ? 3'h1 : 3'h2;
        end
    endfunction
endpackage

// ==== shared/mis_cfg_if.sv ====
// configuration and status between register file and screening core
`timescale 1ns/10ps
interface mis_cfg_if;
    logic [mis_pkg::REF_COUNT-1:0][7:0] ref_byte;
    logic [mis_pkg::START_W-1:0] start_pos;
    logic enable;
    logic org;
    logic [1:0] nts;
    logic busy;
    logic result_valid;
    logic matched;

    modport regs (
        output ref_byte, start_pos, enable, org, nts,
        input busy, result_valid, matched
    );
    modport core (
        input ref_byte, start_pos, enable, org, nts,
        output busy, result_valid, matched
    );
endinterface

// ==== rtl/mis_group_cmp.sv ====
// bit-serial mismatch tracker for one identifier group
`timescale 1ns/10ps
module mis_group_cmp #(
    parameter int BYTES = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic step,
    input wire logic rx_bit,
    input wire logic [mis_pkg::BIT_IDX_W-1:0] bit_idx,
    input wire logic [BYTES-1:0][7:0] ref_bytes,
    output logic miss
);
    localparam int IW = (BYTES > 2) ? 2 : 1;

    wire [IW-1:0] byte_sel = bit_idx[IW+2:3];
    wire [2:0] bit_pos = 3'h7 - bit_idx[2:0];
    wire ref_bit = ref_bytes[byte_sel][bit_pos];

    // any differing bit spoils the group
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            miss <= 1'b0;
        end else if (clear) begin
            miss <= 1'b0;
        end else if (step && (rx_bit != ref_bit)) begin
            miss <= 1'b1;
        end
    end
endmodule

// ==== rtl/mis_regs.sv ====
// avalon-mm register file for message id screening
`timescale 1ns/10ps
module mis_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [mis_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    mis_cfg_if.regs cfg
);
    logic [mis_pkg::REF_COUNT-1:0][7:0] ref_reg;
    logic [mis_pkg::START_W-1:0] start_reg;
    logic [3:0] ctrl_reg;
    logic waitreq_reg;
    logic [31:0] rdata_reg;

    wire req = avs_read || avs_write;
    wire aligned = (avs_address[1:0] == 2'h0);
    wire [mis_pkg::IDX_W-1:0] idx = avs_address[mis_pkg::ADDR_W-1:2];
    wire commit = avs_write && !waitreq_reg && aligned && avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire [7:0] rbyte = aligned ? read_sel(idx) : 8'h00;

    function automatic logic [7:0] read_sel(input logic [5:0] i);
        case (i)
            mis_pkg::REF15_IDX: read_sel = ref_reg[0];
            mis_pkg::REF16_IDX: read_sel = ref_reg[1];
            mis_pkg::REF17_IDX: read_sel = ref_reg[2];
            mis_pkg::REF18_IDX: read_sel = ref_reg[3];
            mis_pkg::REF19_IDX: read_sel = ref_reg[4];
            mis_pkg::START_IDX: read_sel = {1'b0, start_reg};
            mis_pkg::CTRL_IDX: read_sel = {4'h0, ctrl_reg};
            mis_pkg::STATUS_IDX: read_sel = {5'h00, cfg.matched,
                                             cfg.result_valid, cfg.busy};
            default: read_sel = 8'h00;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < mis_pkg::REF_COUNT; g++) begin : gen_ref
            // reference byte, writable, zero at reset
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ref_reg[g] <= mis_pkg::REF_RST;
                end else if (commit && idx == 6'(mis_pkg::REF15_IDX + g)) begin
                    ref_reg[g] <= wbyte;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_reg <= mis_pkg::START_RST;
        end else if (commit && idx == mis_pkg::START_IDX) begin
            start_reg <= wbyte[mis_pkg::START_W-1:0];
        end
    end

    // enable, organisation and byte count, all off at reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= mis_pkg::CTRL_RST;
        end else if (commit && idx == mis_pkg::CTRL_IDX) begin
            ctrl_reg <= wbyte[3:0];
        end
    end

    // one wait cycle, then the access completes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitreq_reg <= 1'b1;
        end else begin
            waitreq_reg <= !(req && waitreq_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && waitreq_reg) begin
            rdata_reg <= {24'h00_0000, rbyte};
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign cfg.ref_byte = ref_reg;
    assign cfg.start_pos = start_reg;
    assign cfg.enable = ctrl_reg[mis_pkg::CTRL_EN_BIT];
    assign cfg.org = ctrl_reg[mis_pkg::CTRL_ORG_BIT];
    assign cfg.nts = ctrl_reg[mis_pkg::CTRL_NTS_LSB+1:mis_pkg::CTRL_NTS_LSB];
endmodule

// ==== rtl/mis_screen_top.sv ====
// message id screening core: register file, sequencer and comparators
// Operation
// - each reference byte is an 8-bit writable register reset to zero
// - start position 0 compares from first bit after sync, 127 from 128th
// - enable bit switches screening on or off; off after reset
// - organisation bit picks two- or four-byte groups; two-byte at reset
// - byte count code scans 1-4 bytes; two-byte mode caps at two
`timescale 1ns/10ps
module mis_screen_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [mis_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic frame_sync_found,
    output logic screen_done,
    output logic screen_match
);
    localparam int BW = mis_pkg::BIT_IDX_W;
    localparam int SW = mis_pkg::START_W;

    mis_cfg_if cfg_bus();

    mis_pkg::mis_state_t state_reg;
    mis_pkg::mis_state_t state_next;
    logic [SW-1:0] start_lat_reg;
    logic [BW-1:0] last_bit_reg;
    logic org_lat_reg;
    logic en_lat_reg;
    logic [SW-1:0] skip_cnt_reg;
    logic [BW-1:0] bit_idx_reg;
    logic done_reg;
    logic match_reg;
    logic valid_reg;
    logic [1:0] miss_two;
    logic miss_four;
    logic [3:0][7:0] ref_lat_reg;

    mis_regs u_regs (
        .clk(clk),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .cfg(cfg_bus.regs)
    );

    // bytes to scan, decoded per organisation
    wire [2:0] scan_bytes = mis_pkg::mis_scan_bytes(cfg_bus.org, cfg_bus.nts);
    wire [BW-1:0] last_bit = BW'({scan_bytes, 3'h0} - 6'h01);
    wire in_skip = (state_reg == mis_pkg::MIS_SKIP);
    wire in_cmp = (state_reg == mis_pkg::MIS_CMP);
    wire in_report = (state_reg == mis_pkg::MIS_REPORT);
    wire step = rx_bit_valid && in_cmp && !frame_sync_found;
    wire skip_done = (skip_cnt_reg == SW'(start_lat_reg - 7'h01));
    wire cmp_done = (bit_idx_reg == last_bit_reg);
    // any group whose leading scanned bytes equal the received bytes is a match
    wire hit_two = !(miss_two[0] && miss_two[1]);
    wire hit_four = !miss_four;
    wire group_hit = org_lat_reg ? hit_four : hit_two;
    wire verdict = en_lat_reg ? group_hit : 1'b1;

    genvar g;
    // reference bytes frozen at sync; a mid-frame write waits a frame
    generate
        for (g = 0; g < 4; g++) begin : gen_ref_lat
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ref_lat_reg[g] <= mis_pkg::REF_RST;
                end else if (frame_sync_found) begin
                    ref_lat_reg[g] <= cfg_bus.ref_byte[g+mis_pkg::FOUR_BASE];
                end
            end
        end
    endgenerate

    generate
        for (g = 0; g < 2; g++) begin : gen_two
            localparam int BASE = (g == 0) ? mis_pkg::TWO_BASE0
                                           : mis_pkg::TWO_BASE1;
            localparam int LOC = BASE - mis_pkg::FOUR_BASE;
            mis_group_cmp #(.BYTES(2)) u_two (
                .clk(clk),
                .rst_b(rst_b),
                .clear(frame_sync_found),
                .step(step),
                .rx_bit(rx_bit),
                .bit_idx(bit_idx_reg),
                .ref_bytes(ref_lat_reg[LOC+1:LOC]),
                .miss(miss_two[g])
            );
        end
    endgenerate

    mis_group_cmp #(.BYTES(4)) u_four (
        .clk(clk),
        .rst_b(rst_b),
        .clear(frame_sync_found),
        .step(step),
        .rx_bit(rx_bit),
        .bit_idx(bit_idx_reg),
        .ref_bytes(ref_lat_reg),
        .miss(miss_four)
    );

    // frame sync restarts from any state and beats a bit in the same cycle
    always_comb begin
        state_next = state_reg;
        if (frame_sync_found) begin
            // disabled screening passes the frame at once
            if (!cfg_bus.enable) begin
                state_next = mis_pkg::MIS_REPORT;
            // start position zero compares the very next bit
            end else if (cfg_bus.start_pos == 7'h00) begin
                state_next = mis_pkg::MIS_CMP;
            end else begin
                state_next = mis_pkg::MIS_SKIP;
            end
        end else begin
            case (state_reg)
                mis_pkg::MIS_IDLE: begin
                    state_next = mis_pkg::MIS_IDLE;
                end
                mis_pkg::MIS_SKIP: begin
                    if (rx_bit_valid && skip_done) begin
                        state_next = mis_pkg::MIS_CMP;
                    end
                end
                mis_pkg::MIS_CMP: begin
                    if (rx_bit_valid && cmp_done) begin
                        state_next = mis_pkg::MIS_REPORT;
                    end
                end
                mis_pkg::MIS_REPORT: begin
                    state_next = mis_pkg::MIS_IDLE;
                end
                default: begin
                    state_next = mis_pkg::MIS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= mis_pkg::MIS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_lat_reg <= mis_pkg::START_RST;
        end else if (frame_sync_found) begin
            start_lat_reg <= cfg_bus.start_pos;
        end
    end

    // last compared bit frozen per frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_bit_reg <= '0;
        end else if (frame_sync_found) begin
            last_bit_reg <= last_bit;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            org_lat_reg <= 1'b0;
        end else if (frame_sync_found) begin
            org_lat_reg <= cfg_bus.org;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_lat_reg <= 1'b0;
        end else if (frame_sync_found) begin
            en_lat_reg <= cfg_bus.enable;
        end
    end

    // count skipped bits ahead of the scan window
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            skip_cnt_reg <= '0;
        end else if (frame_sync_found) begin
            skip_cnt_reg <= '0;
        end else if (rx_bit_valid && in_skip) begin
            skip_cnt_reg <= SW'(skip_cnt_reg + 7'h01);
        end
    end

    // walks exactly the chosen number of bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_idx_reg <= '0;
        end else if (frame_sync_found) begin
            bit_idx_reg <= '0;
        end else if (step) begin
            bit_idx_reg <= BW'(bit_idx_reg + 5'h01);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= in_report;
        end
    end

    // verdict held until the next one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match_reg <= 1'b0;
        end else if (in_report) begin
            match_reg <= verdict;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_reg <= 1'b0;
        end else if (in_report) begin
            valid_reg <= 1'b1;
        end else if (frame_sync_found) begin
            valid_reg <= 1'b0;
        end
    end

    assign cfg_bus.busy = in_skip || in_cmp;
    assign cfg_bus.result_valid = valid_reg;
    assign cfg_bus.matched = match_reg;
    assign screen_done = done_reg;
    assign screen_match = match_reg;
endmodule

// ==== test/mis_chk.sv ====
// port assertions for message id screening
`timescale 1ns/10ps
module mis_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [mis_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic frame_sync_found,
    input wire logic screen_done,
    input wire logic screen_match
);
    logic [7:0] shd_reg [0:6];
    logic [7:0] cnt_reg;
    logic [7:0] need_reg;
    logic fen_reg;
    wire [5:0] ix = avs_address[7:2];
    wire inr = ix >= 6'h0F && ix <= 6'h15 && avs_address[1:0] == 2'h0;
    wire [2:0] sl = 3'(ix - 6'h0F);
    wire [7:0] msk = ix == 6'h14 ? 8'h7F : ix == 6'h15 ? 8'h0F : 8'hFF;
    wire acc = avs_read && !avs_waitrequest;
    wire wok = avs_write && !avs_waitrequest && avs_byteenable[0] && inr;
    wire [7:0] ctl = shd_reg[6];
    wire [2:0] nb = ctl[2] ? 3'(ctl[1:0]) + 3'h1 :
        (ctl[1:0] == 2'h0 ? 3'h1 : 3'h2);
    // shadow of registers and valid bits since sync
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 7; i++) begin
                shd_reg[i] <= 8'h00;
            end
            cnt_reg <= 8'h00;
            need_reg <= 8'h00;
            fen_reg <= 1'b0;
        end else begin
            if (wok) begin
                shd_reg[sl] <= avs_writedata[7:0] & msk;
            end
            if (frame_sync_found) begin
                cnt_reg <= 8'h00;
                fen_reg <= ctl[3];
                need_reg <= shd_reg[5] + {2'h0, nb, 3'h0};
            end else if (rx_bit_valid && cnt_reg != 8'hFF) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_WAIT_ONE: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus not answered after one wait");
    AST_WAIT_REL: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    AST_RD_REG: assert property (
        acc && inr |-> avs_readdata == {24'h0, shd_reg[sl]})
        else $error("register read back wrong");
    AST_RD_MAP: assert property (
        acc && !inr && ix != 6'h20 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_DONE_ONE: assert property (
        screen_done |=> !screen_done)
        else $error("done longer than a cycle");
    AST_MATCH_HOLD: assert property (
        $changed(screen_match) |-> screen_done)
        else $error("verdict moved without done");
    AST_OFF_PASS: assert property (
        frame_sync_found && !ctl[3] |-> ##2 screen_done && screen_match)
        else $error("disabled frame not passed");
    AST_SCAN_LEN: assert property (
        screen_done && fen_reg |-> $past(cnt_reg) == need_reg)
        else $error("verdict after wrong bit count");
    AST_COV_ON: cover property (frame_sync_found && ctl[3]);
    AST_COV_MISS: cover property (screen_done && !screen_match);
    AST_COV_WR: cover property (wok);
endmodule
bind mis_screen_top mis_chk i_chk (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .frame_sync_found(frame_sync_found), .screen_done(screen_done),
    .screen_match(screen_match));

// ==== test/mis_link_model.sv ====
// upstream bit source: sync pulse then msb-first bit stream
`timescale 1ns/10ps
module mis_link_model (
    input wire logic clk,
    output logic frame_sync_found,
    output logic rx_bit_valid,
    output logic rx_bit
);
    initial begin
        frame_sync_found = 1'b0;
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
    end
    task automatic frame(input int skip, input logic [39:0] pat,
                         input int n, input logic slow);
        @(posedge clk);
        frame_sync_found <= 1'b1;
        @(posedge clk);
        frame_sync_found <= 1'b0;
        for (int i = 0; i < skip + n; i++) begin
            rx_bit_valid <= 1'b1;
            rx_bit <= (i < skip) ? i[0] : pat[39 - (i - skip)];
            @(posedge clk);
            if (slow) begin
                rx_bit_valid <= 1'b0;
                rx_bit <= ~rx_bit;
                @(posedge clk);
            end
        end
        // idle line shows inverse of last bit in a fast frame, the last bit itself in a slow one
        rx_bit_valid <= 1'b0;
        rx_bit <= ~rx_bit;
    endtask
endmodule

// ==== test/test_message_id_screening.sv ====
// self-checking bench for message id screening
`timescale 1ns/10ps
module test_message_id_screening;
    logic clk = 1'b0;
    logic rst_b;
    logic [7:0] avs_address;
    logic avs_read, avs_write, rx_bit, rx_bit_valid, frame_sync_found;
    logic avs_waitrequest, screen_done, screen_match;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] r [0:4];
    logic [7:0] eq_rd [$];
    logic eq_vd [$];
    logic [39:0] pat;
    logic [6:0] st;
    int seed, mismatches, checked, cycles, nb, base;
    always #2.5 clk = ~clk;
    mis_screen_top i_dut (.clk(clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .frame_sync_found(frame_sync_found),
        .screen_done(screen_done), .screen_match(screen_match));
    mis_link_model i_lnk (.clk(clk), .frame_sync_found(frame_sync_found),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        eq_rd.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic drain();
        while (eq_vd.size() != 0) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // result monitor
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            cmp(avs_readdata, {24'h0, eq_rd.pop_front()});
        end
        if (screen_done === 1'b1) begin
            cmp({31'h0, screen_match}, {31'h0, eq_vd.pop_front()});
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        seed = 32'hACDD;
        rst_b = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'h3C; a <= 8'h58; a += 4) begin
            rd(8'(a), 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            r[k] = (k > 2) ? ~r[k - 2] : 8'($random(seed));
            bus(1'b1, 8'(8'h3C + 4 * k), r[k]);
            rd(8'(8'h3C + 4 * k), r[k]);
        end
        // low byte lane disabled: write must be ignored
        avs_byteenable <= 4'hE;
        bus(1'b1, 8'h3C, ~r[0]);
        avs_byteenable <= 4'hF;
        rd(8'h3C, r[0]);
        bus(1'b1, 8'h50, 8'hFF);
        rd(8'h50, 8'h7F);
        bus(1'b1, 8'h54, 8'hFF);
        rd(8'h54, 8'h0F);
        $display("test registers done");
        bus(1'b1, 8'h54, 8'h00);
        eq_vd.push_back(1'b1);
        i_lnk.frame(5, 40'h0, 8, 1'b0);
        drain();
        rd(8'h80, 8'h06);
        $display("test disabled done");
        for (int c = 0; c < 8; c++) begin
            st = (c == 7) ? 7'h7F : 7'($random(seed)) & 7'h0F;
            nb = c[2] ? c[1:0] + 1 : (c[1:0] == 0 ? 1 : 2);
            bus(1'b1, 8'h50, {1'b0, st});
            bus(1'b1, 8'h54, {5'h01, c[2:0]});
            for (int f = 0; f < 3; f++) begin
                base = (!c[2] && f[0]) ? 3 : 1;
                pat = {$random(seed), 8'($random(seed))};
                for (int k = 0; k < nb; k++) begin
                    pat[39 - 8 * k -: 8] = r[base + k];
                end
                if (f == 2) begin
                    pat[40 - 8 * nb] = ~pat[40 - 8 * nb];
                end
                eq_vd.push_back(f != 2);
                i_lnk.frame(st, pat, 8 * nb + 8, c[0]);
                drain();
            end
        end
        rd(8'h80, 8'h02);
        $display("test scan done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
